// file: src/acsc_pkg.sv
// acsc_pkg: shared constants and types of the sweep/trigger/dma control block
package acsc_pkg;
  // register bus widths
  localparam int unsigned DW = 16;
  localparam int unsigned AW = 8;
  // register offsets
  localparam logic [7:0] CTRL0_OFF  = 8'h00;  // start, trigger source
  localparam logic [7:0] CTRL1_OFF  = 8'h01;  // resolution
  localparam logic [7:0] CTRL2_OFF  = 8'h02;  // trigger select, sample-hold
  localparam logic [7:0] CTRL3_OFF  = 8'h03;  // dma mode
  localparam logic [7:0] CTRL4_OFF  = 8'h04;  // sweep group
  localparam logic [7:0] STAT_OFF   = 8'h05;  // sequencer state
  localparam logic [7:0] RES0_OFF   = 8'h10;  // result register zero
  localparam logic [3:0] CHRES_PAGE = 4'h2;   // 0x20..0x2f channel results
  // field positions
  localparam int unsigned START_BIT   = 0;
  localparam int unsigned TRG_SRC_BIT = 1;
  localparam int unsigned RES_BIT     = 0;
  localparam int unsigned TRG_SEL_BIT = 0;
  localparam int unsigned SH_BIT      = 1;
  localparam int unsigned DMA_BIT     = 0;
  localparam int unsigned GRP_LO_BIT  = 0;
  localparam int unsigned GRP_HI_BIT  = 1;
  // reset value of every control bit
  localparam logic CTRL_RST = 1'b0;
  // timing, in converter clock cycles (block runs on that clock)
  localparam int unsigned SAMP_NOSH_CYC = 2;
  localparam int unsigned SAMP_SH_CYC   = 3;
  localparam int unsigned CONV_SH8_CYC  = 28;
  localparam int unsigned CONV_SH10_CYC = 33;
  localparam int unsigned CONV_NS8_CYC  = 40;
  localparam int unsigned CONV_NS10_CYC = 47;
  // sweep shape
  localparam int unsigned SWEEP_LEN = 16;
  // base and second-bank codes on the analog_bank output
  typedef enum logic [1:0] {
    ACSC_BANK_BASE = 2'h0,
    ACSC_BANK_0    = 2'h1,
    ACSC_BANK_2    = 2'h2,
    ACSC_BANK_15   = 2'h3
  } acsc_bank_e;
  // sequencer states
  typedef enum logic [1:0] {ACSC_IDLE, ACSC_ARMED, ACSC_RUN} acsc_state_e;
endpackage : acsc_pkg

// file: src/acsc_conv_if.sv
// acsc_conv_if: handshake between sequencer and conversion timer
`timescale 1ns/100ps
interface acsc_conv_if;
  logic start;     // begin a channel, restarts if busy
  logic stop;      // abandon any channel at once
  logic ten_bit;   // 10-bit resolution selected
  logic sh_en;     // sample-and-hold selected
  logic sampling;  // sampling window of current channel
  logic done;      // last cycle of current channel
  logic busy;      // a channel is in progress
  modport seq (output start, stop, ten_bit, sh_en,
               input  sampling, done, busy);
  modport tmr (input  start, stop, ten_bit, sh_en,
               output sampling, done, busy);
endinterface : acsc_conv_if

// file: src/acsc_conv_timer.sv
// acsc_conv_timer: per-channel sampling and conversion cycle counter
`timescale 1ns/100ps
module acsc_conv_timer
  import acsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  acsc_conv_if.tmr cv
);
  logic [5:0] cnt;    // cycle within current channel
  logic [5:0] len;    // channel length in cycles
  logic [5:0] samp;   // sampling window length
  logic [5:0] span;   // helper for checks: cycles since start

  // channel length from resolution and sample-hold [RULE15]
  always_comb begin
    if (cv.sh_en) begin
      len = cv.ten_bit ? 6'(CONV_SH10_CYC) : 6'(CONV_SH8_CYC);
    end else begin
      len = cv.ten_bit ? 6'(CONV_NS10_CYC) : 6'(CONV_NS8_CYC);
    end
    samp = cv.sh_en ? 6'(SAMP_SH_CYC) : 6'(SAMP_NOSH_CYC);  // [RULE19]
  end

  // counter; a start while busy restarts from cycle zero
  always_ff @(posedge clock) begin
    if (rst || cv.stop) begin
      cv.busy <= 1'b0;
      cnt     <= 6'h00;
    end else if (cv.start) begin
      cv.busy <= 1'b1;
      cnt     <= 6'h00;
    end else if (cv.busy) begin
      if (cnt == len - 6'h01) begin
        cv.busy <= 1'b0;
      end else begin
        cnt <= cnt + 6'h01;
      end
    end
  end

  // handshake outputs are decoded from the counter
  assign cv.done     = cv.busy && (cnt == len - 6'h01);
  assign cv.sampling = cv.busy && (cnt < samp);              // [RULE19]

  // independent cycle count since the last start, for the checks
  always_ff @(posedge clock) begin
    if (rst || cv.start) begin
      span <= 6'h01;
    end else if (span != 6'h3f) begin
      span <= span + 6'h01;
    end
  end

  conv_length_a: assert property (@(posedge clock) // [RULE15]
    disable iff (rst)
    cv.done |-> span == (cv.sh_en ? (cv.ten_bit ? 6'd33 : 6'd28)
                                  : (cv.ten_bit ? 6'd47 : 6'd40)))
    else $error("channel conversion length wrong");
  samp_window_a: assert property (@(posedge clock) // [RULE19]
    disable iff (rst)
    $fell(cv.sampling) && !cv.stop && !$past(cv.start)
      |-> $past(span) == (cv.sh_en ? 6'd3 : 6'd2))
    else $error("sampling window length wrong");
endmodule : acsc_conv_timer

// file: src/acsc_trig_sel.sv
// acsc_trig_sel: external pin synchroniser and trigger source select
`timescale 1ns/100ps
module acsc_trig_sel
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic ext_trigger_pin,
  input  wire logic motor_timer_irq_source,
  input  wire logic trigger_select_bit,
  output logic      trig_pulse
);
  logic pin_s1;   // first sync stage, read only by pin_s2
  logic pin_s2;   // second sync stage
  logic pin_s3;   // previous synced level for edge detect

  // two-stage synchroniser; idle level high so reset makes no edge
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
    end else begin
      pin_s1 <= ext_trigger_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // falling pin edge or divided motor timer request [RULE6] [RULE7]
  assign trig_pulse = trigger_select_bit ? motor_timer_irq_source
                                         : (pin_s3 && !pin_s2);

  // checked against the raw pin, so the first sync stage keeps one reader
  ext_fall_a: assert property (@(posedge clock) disable iff (rst) // [RULE6]
    trig_pulse && !trigger_select_bit
      |-> $past(ext_trigger_pin, 3) && !$past(ext_trigger_pin, 2))
    else $error("external trigger without falling edge");
endmodule : acsc_trig_sel

// file: src/acsc_top.sv
// acsc_top: repeat sweep sequencer with triggers, results and dma mode
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
// Overview of operation
// RULE1: repeat sweep converts sixteen channels endlessly
// RULE2: group field selects set, 10b uses bank 0
// RULE3: base bank first, then one second bank
// RULE4: software sets dma mode before starting
// RULE5: software trigger starts on start bit write
// RULE6: external falling edge starts when selected
// RULE7: divided motor timer request starts when selected
// RULE8: hardware triggers ignored while start bit clear
// RULE9: retrigger aborts and restarts the sweep
// RULE10: only clearing start bit stops conversion
// RULE11: dma mode raises request per channel
// RULE12: dma mode puts every result in register zero
// RULE13: software never reads register zero itself
// RULE14: ten-bit fills bits 9..0, eight-bit 7..0
// RULE15: sample-hold channel takes 28 or 33 cycles
// RULE16: software enables sample-hold before starting
// RULE17: dma width follows result resolution; the far model always moves 16 bits
// RULE18: dma mode usable in every conversion mode
// RULE19: sampling lasts 2 or 3 cycles
// RULE20: software changes control only while stopped
// RULE21: sweep wraps to first channel without gap
module acsc_top
  import acsc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic [acsc_pkg::AW-1:0] reg_addr,
  input  wire logic [acsc_pkg::DW-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [acsc_pkg::DW-1:0] reg_rdata,
  input  wire logic                  ext_trigger_pin,
  input  wire logic                  motor_timer_irq_source,
  input  wire logic [9:0]            adc_code,
  output logic      [1:0]            analog_bank,
  output logic      [2:0]            analog_chan,
  output logic                       sample_hold_active,
  output logic                       conv_irq,
  output logic                       dma_req,
  output logic      [acsc_pkg::DW-1:0] dma_rdata
);
  import acsc_pkg::*;

  // control bits
  logic conv_start_bit;       // conversion running request
  logic trigger_source_bit;   // 0 software, 1 pin or timer
  logic res_ten;              // 1 selects ten-bit results
  logic trigger_select_bit;   // 0 pin edge, 1 motor timer
  logic sample_hold_enable;   // sample-and-hold on
  logic dma_mode_enable;      // all results to register zero
  logic sweep_group_sel_hi;   // sweep group, upper bit
  logic sweep_group_sel_lo;   // sweep group, lower bit

  // sequencer
  acsc_state_e state;         // idle, armed or running
  logic [3:0]  idx;           // position in the 16-step sweep
  logic        trig_pulse;    // selected hardware trigger event
  logic        trig_fire;     // trigger accepted
  logic        sw_go;         // software start accepted
  logic        next_go;       // continue with the following channel
  acsc_bank_e  grp_bank;      // second bank from the group field
  logic [DW-1:0] res_word;    // placed result of the finishing channel

  // results
  logic [DW-1:0] result_reg_zero;             // dma mode destination
  logic [DW-1:0] channel_result_reg [SWEEP_LEN]; // per-channel results

  acsc_conv_if cv ();

  // trigger front end
  acsc_trig_sel u_trig (
    .clock                  (clock),
    .rst                    (rst),
    .ext_trigger_pin        (ext_trigger_pin),
    .motor_timer_irq_source (motor_timer_irq_source),
    .trigger_select_bit     (trigger_select_bit),
    .trig_pulse             (trig_pulse)
  );

  // channel timing
  acsc_conv_timer u_tmr (
    .clock (clock),
    .rst   (rst),
    .cv    (cv.tmr)
  );

  // control register writes; other bits are meant to change only
  // while stopped, the block does not guard against it
  always_ff @(posedge clock) begin
    if (rst) begin
      conv_start_bit     <= CTRL_RST;
      trigger_source_bit <= CTRL_RST;
      res_ten            <= CTRL_RST;
      trigger_select_bit <= CTRL_RST;
      sample_hold_enable <= CTRL_RST;
      dma_mode_enable    <= CTRL_RST;
      sweep_group_sel_hi <= CTRL_RST;
      sweep_group_sel_lo <= CTRL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        CTRL0_OFF: begin
          conv_start_bit     <= reg_wdata[START_BIT];
          trigger_source_bit <= reg_wdata[TRG_SRC_BIT];
        end
        CTRL1_OFF: res_ten <= reg_wdata[RES_BIT];
        CTRL2_OFF: begin
          trigger_select_bit <= reg_wdata[TRG_SEL_BIT];
          sample_hold_enable <= reg_wdata[SH_BIT];
        end
        CTRL3_OFF: dma_mode_enable <= reg_wdata[DMA_BIT];
        CTRL4_OFF: begin
          sweep_group_sel_hi <= reg_wdata[GRP_HI_BIT];
          sweep_group_sel_lo <= reg_wdata[GRP_LO_BIT];
        end
        default: ;  // unmapped writes are dropped
      endcase
    end
  end

  // start decisions
  always_comb begin
    // software start needs trigger source 0 [RULE5]
    sw_go = (state == ACSC_IDLE) && conv_start_bit && !trigger_source_bit;
    // hardware trigger only while start bit holds 1 [RULE8] [RULE9]
    trig_fire = trig_pulse && conv_start_bit && trigger_source_bit &&
                (state != ACSC_IDLE);
    // finished channel chains straight into the next one [RULE21]
    next_go = cv.done && conv_start_bit && (state == ACSC_RUN);
  end

  // timer handshake
  assign cv.start   = sw_go || trig_fire || next_go;
  assign cv.stop    = !conv_start_bit;  // [RULE10]
  assign cv.ten_bit = res_ten;
  assign cv.sh_en   = sample_hold_enable;

  // sequencer state; leaving run needs the start bit cleared [RULE10]
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ACSC_IDLE;
    end else begin
      case (state)
        ACSC_IDLE: begin
          if (conv_start_bit) begin
            state <= trigger_source_bit ? ACSC_ARMED : ACSC_RUN;
          end
        end
        ACSC_ARMED: begin
          if (!conv_start_bit) begin
            state <= ACSC_IDLE;
          end else if (trig_fire) begin
            state <= ACSC_RUN;  // [RULE6] [RULE7]
          end
        end
        ACSC_RUN: begin
          if (!conv_start_bit) begin
            state <= ACSC_IDLE;
          end
        end
        default: state <= ACSC_IDLE;
      endcase
    end
  end

  // sweep position; four bits wrap 15 -> 0 by themselves [RULE1]
  always_ff @(posedge clock) begin
    if (rst) begin
      idx <= 4'h0;
    end else if (sw_go || trig_fire) begin
      idx <= 4'h0;  // abort and restart from the top [RULE9]
    end else if (next_go) begin
      idx <= idx + 4'h1;  // [RULE21]
    end
  end

  // second bank from the group field [RULE2] [RULE3]
  always_comb begin
    case ({sweep_group_sel_hi, sweep_group_sel_lo})
      2'b10:   grp_bank = ACSC_BANK_0;
      2'b11:   grp_bank = ACSC_BANK_2;
      default: grp_bank = ACSC_BANK_15;
    endcase
  end

  // base channels for steps 0..7, second bank for 8..15 [RULE3]
  assign analog_bank = idx[3] ? grp_bank : ACSC_BANK_BASE;
  assign analog_chan = idx[2:0];
  assign sample_hold_active = cv.sampling;

  // result placement by resolution [RULE14]
  assign res_word = res_ten ? {6'h00, adc_code} : {8'h00, adc_code[9:2]};

  // result store: dma mode funnels every channel to one register;
  // available whatever the sweep mode [RULE12] [RULE18]
  always_ff @(posedge clock) begin
    if (rst) begin
      result_reg_zero <= 16'h0000;
      for (int i = 0; i < SWEEP_LEN; i++) begin
        channel_result_reg[i] <= 16'h0000;
      end
    end else if (cv.done) begin
      if (dma_mode_enable) begin
        result_reg_zero <= res_word;
      end else begin
        channel_result_reg[idx] <= res_word;
      end
    end
  end
  assign dma_rdata = result_reg_zero;

  // per-channel request to interrupt and dma logic, raised in dma mode only [RULE11]
  always_ff @(posedge clock) begin
    if (rst) begin
      conv_irq <= 1'b0;
      dma_req  <= 1'b0;
    end else begin
      conv_irq <= cv.done && dma_mode_enable;
      dma_req  <= cv.done && dma_mode_enable;
    end
  end

  // register reads, data one cycle after the strobe; unmapped read 0
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
      case (reg_addr)
        CTRL0_OFF: reg_rdata <= {14'h0000, trigger_source_bit,
                                 conv_start_bit};
        CTRL1_OFF: reg_rdata <= {15'h0000, res_ten};
        CTRL2_OFF: reg_rdata <= {14'h0000, sample_hold_enable,
                                 trigger_select_bit};
        CTRL3_OFF: reg_rdata <= {15'h0000, dma_mode_enable};
        CTRL4_OFF: reg_rdata <= {14'h0000, sweep_group_sel_hi,
                                 sweep_group_sel_lo};
        STAT_OFF:  reg_rdata <= {10'h000, idx, state};
        RES0_OFF:  reg_rdata <= result_reg_zero;
        default: begin
          if (reg_addr[7:4] == CHRES_PAGE) begin
            reg_rdata <= channel_result_reg[reg_addr[3:0]];
          end
        end
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  default clocking dck @(posedge clock); endclocking
  default disable iff (rst);

  wrap_gap_a: assert property ( // [RULE21]
    next_go && !trig_fire && idx == 4'hf |=> idx == 4'h0 && cv.busy)
    else $error("sweep did not wrap without gap");
  sweep_step_a: assert property ( // [RULE1]
    next_go && !trig_fire |=> idx == $past(idx) + 4'h1 && cv.busy)
    else $error("sweep did not advance");
  bank_zero_a: assert property ( // [RULE2]
    {sweep_group_sel_hi, sweep_group_sel_lo} == 2'b10 && idx[3]
      |-> analog_bank == ACSC_BANK_0)
    else $error("group 10b not on bank zero");
  base_first_a: assert property ( // [RULE3]
    !idx[3] |-> analog_bank == ACSC_BANK_BASE && analog_chan == idx[2:0])
    else $error("first half not on base channels");
  sw_start_a: assert property ( // [RULE5]
    state == ACSC_IDLE && conv_start_bit && !trigger_source_bit
      |=> state == ACSC_RUN && cv.busy && idx == 4'h0)
    else $error("software start did not begin");
  trig_gate_a: assert property ( // [RULE8]
    !conv_start_bit |-> !cv.start)
    else $error("conversion started with start bit clear");
  armed_wait_a: assert property ( // [RULE6]
    state == ACSC_ARMED && !trig_fire |=> state != ACSC_RUN)
    else $error("armed sweep ran without trigger");
  restart_a: assert property ( // [RULE9]
    trig_fire |=> idx == 4'h0 && cv.busy && state == ACSC_RUN)
    else $error("retrigger did not restart");
  run_hold_a: assert property ( // [RULE10]
    state == ACSC_RUN && conv_start_bit |=> state == ACSC_RUN)
    else $error("sweep stopped without start bit clear");
  stop_a: assert property ( // [RULE10]
    !conv_start_bit |=> state == ACSC_IDLE && !cv.busy)
    else $error("sweep kept running after stop");
  irq_each_a: assert property ( // [RULE11]
    cv.done && dma_mode_enable |=> conv_irq && dma_req
      ##1 !conv_irq)
    else $error("no per-channel request");
  dma_dest_a: assert property ( // [RULE12]
    cv.done && dma_mode_enable |=> result_reg_zero == $past(res_word))
    else $error("dma result not in register zero");
  res_eight_a: assert property ( // [RULE14]
    cv.done && dma_mode_enable && !res_ten
      |=> result_reg_zero[15:8] == 8'h00)
    else $error("eight-bit result above bit 7");

  wrap_c:    cover property (next_go && idx == 4'hf);
  restart_c: cover property (trig_fire && state == ACSC_RUN);
  stop_c:    cover property (state == ACSC_RUN ##1 !conv_start_bit);
  dma_c:     cover property (conv_irq && res_ten);
endmodule : acsc_top

// file: verif/acsc_far_model.sv
// acsc_far_model: analog front end and dma controller stand-in
`timescale 1ns/100ps
module acsc_far_model
  import acsc_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic [1:0]              analog_bank,
  input  wire logic [2:0]              analog_chan,
  input  wire logic                    sample_hold_active,
  input  wire logic                    conv_irq,
  input  wire logic                    dma_req,
  input  wire logic [acsc_pkg::DW-1:0] dma_rdata,
  output logic      [9:0]              adc_code
);
  logic [15:0] data[$];   // words moved to memory
  int          stamp[$];  // cycle of each move
  int          cyc = 0;   // free running cycle count
  int          irqs = 0;  // interrupt pulses seen
  int          sh_len = 0;  // length of the last sampling window
  int          sh_run = 0;  // running window length
  // the code names its own source pin, so sweep order shows in results
  assign adc_code = {analog_bank, analog_chan, 5'h15};
  // moves happen only on request; nothing else reads result zero
  // a full 16-bit word is moved, wide enough for either resolution
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (dma_req) begin
      data.push_back(dma_rdata);
      stamp.push_back(cyc);
    end
    if (conv_irq) irqs <= irqs + 1;
  end
  // measure each sampling window as it closes
  always @(posedge clock) begin
    if (sample_hold_active) sh_run <= sh_run + 1;
    else if (sh_run != 0) begin
      sh_len <= sh_run;
      sh_run <= 0;
    end
  end
endmodule : acsc_far_model

// file: verif/tb_acsc_top.sv
// tb_acsc_top: self-checking bench for the sweep control block
`timescale 1ns/100ps
module tb_acsc_top;
  import acsc_pkg::*;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} acsc_row_s;
  logic        clock = 1'b0;        // converter clock
  logic        rst = 1'b1;          // synchronous reset
  logic [7:0]  reg_addr = 8'h00;    // register index
  logic [15:0] reg_wdata = 16'h0000;  // write data
  logic        reg_wr = 1'b0;       // write strobe
  logic        reg_rd = 1'b0;       // read strobe
  logic [15:0] reg_rdata;           // read data
  logic        ext_trigger_pin = 1'b1;  // pulled up, idles high
  logic        motor_timer_irq_source = 1'b0;  // divided timer request
  logic [9:0]  adc_code;            // from the front end model
  logic [1:0]  analog_bank;         // bank being converted
  logic [2:0]  analog_chan;         // channel within bank
  logic        sample_hold_active;  // sampling window
  logic        conv_irq;            // per channel interrupt
  logic        dma_req;             // per channel dma request
  logic [15:0] dma_rdata;           // result register zero
  logic [15:0] got;                 // last read value
  int          err_total = 0;       // mismatches
  int          checks_done = 0;     // comparisons
  // writable fields read back, the rest of each word reads 0
  acsc_row_s rows[9] = '{
    '{8'h01, 16'hffff, 16'h0001}, '{8'h02, 16'hffff, 16'h0003},
    '{8'h03, 16'hfffe, 16'h0000}, '{8'h03, 16'hffff, 16'h0001},
    '{8'h04, 16'h0002, 16'h0002}, '{8'h05, 16'hffff, 16'h0000},
    '{8'h30, 16'hffff, 16'h0000}, '{8'h00, 16'hfffe, 16'h0002},
    '{8'h00, 16'h0000, 16'h0000}};
  // second bank per group code, in group order 10b, 11b, 00b
  logic [1:0]  grp[3] = '{2'h2, 2'h3, 2'h0};
  logic [1:0]  bnk[3] = '{2'h1, 2'h2, 2'h3};

  acsc_top acsc_top_i (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_trigger_pin(ext_trigger_pin),
    .motor_timer_irq_source(motor_timer_irq_source), .adc_code(adc_code),
    .analog_bank(analog_bank), .analog_chan(analog_chan),
    .sample_hold_active(sample_hold_active), .conv_irq(conv_irq),
    .dma_req(dma_req), .dma_rdata(dma_rdata));
  acsc_far_model acsc_far_model_i (.clock(clock), .analog_bank(analog_bank),
    .analog_chan(analog_chan), .sample_hold_active(sample_hold_active),
    .conv_irq(conv_irq), .dma_req(dma_req), .dma_rdata(dma_rdata),
    .adc_code(adc_code));

  // 200 MHz clock
  always #2.5 clock = ~clock;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one write cycle, strobe dropped on the following edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // one read cycle, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // forget what the far side has logged so far
  task automatic clear;
    acsc_far_model_i.data.delete();
    acsc_far_model_i.stamp.delete();
    acsc_far_model_i.irqs = 0;
  endtask : clear
  // wait, bounded, until n results were moved
  task automatic wait_n(input int n);
    for (int k = 0; k < 3000 && acsc_far_model_i.data.size() < n; k++)
      @(posedge clock);
    #1;
    chk(16'(acsc_far_model_i.data.size()), 16'(n));
  endtask : wait_n
  // clearing the start bit is the only stop; nothing moves after it
  task automatic stop;
    wr(8'h00, 16'h0000);
    tick(3);
    clear();
  endtask : stop
  function automatic logic [15:0] expw(input int i, input logic [1:0] bk,
                                        input logic ten);
    logic [9:0] c;
    c = {(i % 16 < 8) ? 2'h0 : bk, 3'(i % 8), 5'h15};
    return ten ? {6'h00, c} : {8'h00, c[9:2]};
  endfunction : expw
  // software started sweep, checked for order, placement and pacing
  task automatic sweep(input logic [1:0] g, input logic [1:0] bk,
                       input logic ten, input int len, input int n);
    wr(8'h04, {14'h0000, g});
    wr(8'h00, 16'h0001);
    wait_n(n);
    for (int i = 0; i < n && i < acsc_far_model_i.data.size(); i++) begin
      chk(acsc_far_model_i.data[i], expw(i, bk, ten));
      if (i > 0)
        chk(16'(acsc_far_model_i.stamp[i] - acsc_far_model_i.stamp[i-1]),
            16'(len));
    end
    chk(16'(acsc_far_model_i.irqs), 16'(n));
    chk(16'(acsc_far_model_i.sh_len), 16'(SAMP_SH_CYC));
    stop();
    tick(60);
    chk(16'(acsc_far_model_i.data.size()), 16'h0000);
  endtask : sweep
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // the whole run needs well under 8000 cycles
  initial begin
    #(20000 * 5);
    err_total++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    foreach (rows[r]) begin
      wr(rows[r].a, rows[r].d);
      rd(rows[r].a);
      chk(got, rows[r].e);
    end
    $display("test registers done");
    clear();
    // 10-bit, every second bank, the first run long enough to wrap
    for (int s = 0; s < 3; s++)
      sweep(grp[s], bnk[s], 1'b1, CONV_SH10_CYC, s == 0 ? 18 : 16);
    $display("test ten bit sweeps done");
    wr(8'h01, 16'h0000);
    sweep(2'h2, 2'h1, 1'b0, CONV_SH8_CYC, 3);
    wr(8'h01, 16'h0001);
    $display("test eight bit sweep done");
    // pin edge while start bit clear must be ignored
    wr(8'h02, 16'h0002);
    wr(8'h00, 16'h0002);
    ext_trigger_pin <= 1'b0;
    tick(80);
    chk(16'(acsc_far_model_i.data.size()), 16'h0000);
    ext_trigger_pin <= 1'b1;
    wr(8'h00, 16'h0003);
    tick(60);
    chk(16'(acsc_far_model_i.data.size()), 16'h0000);
    ext_trigger_pin <= 1'b0;
    wait_n(6);
    chk(acsc_far_model_i.data[0], expw(0, 2'h1, 1'b1));
    // second falling edge just after a result: sweep restarts at zero
    ext_trigger_pin <= 1'b1;
    tick(4);
    ext_trigger_pin <= 1'b0;
    tick(6);
    clear();
    wait_n(1);
    chk(acsc_far_model_i.data[0], expw(0, 2'h1, 1'b1));
    stop();
    ext_trigger_pin <= 1'b1;
    $display("test external trigger done");
    // divided motor timer request as the trigger
    wr(8'h02, 16'h0003);
    wr(8'h00, 16'h0003);
    tick(20);
    chk(16'(acsc_far_model_i.data.size()), 16'h0000);
    @(posedge clock);
    motor_timer_irq_source <= 1'b1;
    @(posedge clock);
    motor_timer_irq_source <= 1'b0;
    wait_n(2);
    chk(acsc_far_model_i.data[1], expw(1, 2'h1, 1'b1));
    stop();
    $display("test motor trigger done");
    // software start, then reset in mid-run: all quiet afterwards
    wr(8'h00, 16'h0001);
    repeat (50) @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    clear();
    rd(8'h00);
    chk(got, 16'h0000);
    tick(100);
    chk(16'(acsc_far_model_i.data.size()), 16'h0000);
    $display("test reset done");
    // reset left dma and sample-hold off: results stay per channel
    wr(8'h01, 16'h0001);
    wr(8'h00, 16'h0001);
    tick(3 * CONV_NS10_CYC - 13);  // read lands late in the third channel
    rd(8'h05);
    chk(got, {10'h000, 4'h2, 2'h2});
    rd(8'h21);
    chk(got, expw(1, 2'h0, 1'b1));
    chk(16'(acsc_far_model_i.data.size() + acsc_far_model_i.irqs),
        16'h0000);
    chk(16'(acsc_far_model_i.sh_len), 16'(SAMP_NOSH_CYC));
    $display("test per channel results done");
    summarize();
  end
endmodule : tb_acsc_top
